//--- inc/pi_lpf_pkg.sv
// Constants, register map and shared arithmetic of the controller and filter unit
// Functional notes
// - Controller output is clamped between the signed upper and lower limit registers.
// - A controller start puts its result in the output register four clocks later.
// - Controller start is bit 1 of control, set by software, cleared next clock.
// - Bits 7..4 select truncation: codes 0..15 give 8..23 bits, reset gives 12.
// - At the default setting the gains are taken with twelve fraction bits.
// - History comes from the error used last run and the present output register.
// - Error, output, proportional and integral gain registers hold signed 16-bit values.
// - Filter output is previous output plus coefficient times input minus previous output.
// - A filter start puts its result in the filter output register four clocks later.
// - Filter start is bit 0 of control, set by software, cleared next clock.
// - Previous filter output is the output register content just before the start.
// - Filter coefficient, input and output registers hold signed 16-bit values.
package pi_lpf_pkg;

    // ==========================================================
    // Widths and timing
    localparam int DATA_W = 16;
    localparam int ACC_W = 36;
    localparam int LATENCY = 4;
    localparam int LPF_FRAC = 15;
    localparam logic [4:0] TRUNC_BASE = 5'h08;
    localparam logic [3:0] TRUNC_DEFAULT = 4'h4;

    // ==========================================================
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_FILT_COEFF_LO = 8'hDC;
    localparam logic [7:0] IDX_FILT_COEFF_HI = 8'hDD;
    localparam logic [7:0] IDX_FILT_IN_LO = 8'hDE;
    localparam logic [7:0] IDX_FILT_IN_HI = 8'hDF;
    localparam logic [7:0] IDX_FILT_OUT_LO = 8'hE6;
    localparam logic [7:0] IDX_FILT_OUT_HI = 8'hE7;
    localparam logic [7:0] IDX_ERR_LO = 8'hEA;
    localparam logic [7:0] IDX_ERR_HI = 8'hEB;
    localparam logic [7:0] IDX_OUT_LO = 8'hEC;
    localparam logic [7:0] IDX_OUT_HI = 8'hED;
    localparam logic [7:0] IDX_KP_LO = 8'hEE;
    localparam logic [7:0] IDX_KP_HI = 8'hEF;
    localparam logic [7:0] IDX_KI_LO = 8'hF2;
    localparam logic [7:0] IDX_KI_HI = 8'hF3;
    localparam logic [7:0] IDX_MAX_LO = 8'hF4;
    localparam logic [7:0] IDX_MAX_HI = 8'hF5;
    localparam logic [7:0] IDX_MIN_LO = 8'hF6;
    localparam logic [7:0] IDX_MIN_HI = 8'hF7;
    localparam logic [7:0] IDX_CONTROL = 8'hF9;

    // ==========================================================
    // Storage slots, low byte at the even slot
    localparam int NUM_SLOTS = 18;
    localparam logic [4:0] SLOT_FILT_COEFF = 5'h00;
    localparam logic [4:0] SLOT_FILT_IN = 5'h02;
    localparam logic [4:0] SLOT_FILT_OUT = 5'h04;
    localparam logic [4:0] SLOT_ERR = 5'h06;
    localparam logic [4:0] SLOT_OUT = 5'h08;
    localparam logic [4:0] SLOT_KP = 5'h0A;
    localparam logic [4:0] SLOT_KI = 5'h0C;
    localparam logic [4:0] SLOT_MAX = 5'h0E;
    localparam logic [4:0] SLOT_MIN = 5'h10;
    typedef logic [NUM_SLOTS-1:0][7:0] slot_bank_t;

    // ==========================================================
    // Control register fields
    localparam int BIT_FILT_START = 0;
    localparam int BIT_CTRL_START = 1;
    localparam int TRUNC_LSB = 4;
    localparam int TRUNC_MSB = 7;
    localparam logic [7:0] CONTROL_RESET = 8'h40;

    // ==========================================================
    // Bus encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

    // Saturate a wide signed value into a signed 16-bit window
    function automatic logic signed [DATA_W-1:0] clamp16(input logic signed [ACC_W-1:0] v,
                                                          input logic signed [DATA_W-1:0] hi,
                                                          input logic signed [DATA_W-1:0] lo);
        if (v > hi)
            return hi;
        else if (v < lo)
            return lo;
        return v[DATA_W-1:0];
    endfunction

    // Assemble a 16-bit word from two byte slots
    function automatic logic [DATA_W-1:0] word_at(input slot_bank_t r, input logic [4:0] s);
        return {r[s+5'h01], r[s]};
    endfunction

endpackage

//--- rtl/pi_core.sv
// Pipelined incremental proportional-integral engine with limiting
`timescale 1ns/1ps
module pi_core import pi_lpf_pkg::*; #(
    parameter int W = DATA_W
) (
    input wire logic hclk, // System clock
    input wire logic hresetn, // Async reset, active low
    input wire logic go, // Start pulse
    input wire logic signed [W-1:0] err, // Present error
    input wire logic signed [W-1:0] out_prev, // Previous output
    input wire logic signed [W-1:0] kp, // Proportional gain
    input wire logic signed [W-1:0] ki, // Integral gain
    input wire logic signed [W-1:0] umax, // Upper limit
    input wire logic signed [W-1:0] umin, // Lower limit
    input wire logic [3:0] trunc_sel, // Truncation code
    output logic done, // Result valid pulse
    output logic signed [W-1:0] result // Limited result
);
    typedef struct packed {
        logic v1;
        logic v2;
        logic v3;
        logic signed [W-1:0] e_prev;
        logic signed [W-1:0] e;
        logic signed [W:0] de;
        logic signed [W-1:0] u;
        logic signed [W-1:0] kp;
        logic signed [W-1:0] ki;
        logic signed [W-1:0] mx;
        logic signed [W-1:0] mn;
        logic [4:0] sh;
        logic signed [ACC_W-1:0] acc;
        logic signed [W-1:0] res;
    } pi_state_t;

    pi_state_t q, d;
    logic signed [ACC_W-1:0] prod_p, prod_i, total;

    // ==========================================================
    // Three stages: capture, multiply and truncate, sum and limit
    always_comb begin
        d = q;
        d.v1 = go;
        d.v2 = q.v1;
        d.v3 = q.v2;
        prod_p = ACC_W'(q.kp) * ACC_W'(q.de);
        prod_i = ACC_W'(q.ki) * ACC_W'(q.e);
        total = ACC_W'(q.u) + q.acc;
        if (go) begin
            d.e = err;
            d.de = {err[W-1], err} - {q.e_prev[W-1], q.e_prev};
            d.e_prev = err;
            d.u = out_prev;
            d.kp = kp;
            d.ki = ki;
            d.mx = umax;
            d.mn = umin;
            d.sh = TRUNC_BASE + {1'b0, trunc_sel};
        end
        if (q.v1) begin
            d.acc = (prod_p + prod_i) >>> q.sh;
        end
        if (q.v2) begin
            d.res = clamp16(total, q.mx, q.mn);
        end
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            q <= '0;
        else
            q <= d;
    end

    assign done = q.v3;
    assign result = q.res;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence pi_capture_s;
        go ##1 q.v1;
    endsequence

    pi_latency_a: assert property (pi_capture_s |-> ##2 done)
        else $error("controller result not ready three clocks after start");
    pi_history_a: assert property (go |=> q.e_prev == $past(err) && q.u == $past(out_prev))
        else $error("controller history not taken at start");
    pi_limit_a: assert property (q.v2 && q.mn <= q.mx |=> result <= $past(q.mx) && result >= $past(q.mn))
        else $error("controller result outside limits");
    pi_default_q12_a: assert property (go && trunc_sel == TRUNC_DEFAULT |=> q.sh == 5'h0C)
        else $error("default truncation is not twelve bits");

endmodule // pi_core

//--- rtl/lpf_core.sv
// Pipelined first-order low-pass filter engine
`timescale 1ns/1ps
module lpf_core import pi_lpf_pkg::*; #(
    parameter int W = DATA_W,
    parameter int FRAC = LPF_FRAC
) (
    input wire logic hclk, // System clock
    input wire logic hresetn, // Async reset, active low
    input wire logic go, // Start pulse
    input wire logic signed [W-1:0] coeff, // Filter coefficient
    input wire logic signed [W-1:0] sample, // Input sample
    input wire logic signed [W-1:0] y_prev, // Previous output
    output logic done, // Result valid pulse
    output logic signed [W-1:0] result // Saturated result
);
    typedef struct packed {
        logic v1;
        logic v2;
        logic v3;
        logic signed [W-1:0] k;
        logic signed [W:0] diff;
        logic signed [W-1:0] y;
        logic signed [ACC_W-1:0] acc;
        logic signed [W-1:0] res;
    } lpf_state_t;

    localparam logic signed [W-1:0] SAT_HI = {1'b0, {(W-1){1'b1}}};
    localparam logic signed [W-1:0] SAT_LO = {1'b1, {(W-1){1'b0}}};

    lpf_state_t q, d;
    logic signed [ACC_W-1:0] prod;

    // ==========================================================
    // Capture, multiply, then add history and saturate
    always_comb begin
        d = q;
        d.v1 = go;
        d.v2 = q.v1;
        d.v3 = q.v2;
        prod = ACC_W'(q.k) * ACC_W'(q.diff);
        if (go) begin
            d.k = coeff;
            d.diff = {sample[W-1], sample} - {y_prev[W-1], y_prev};
            d.y = y_prev;
        end
        if (q.v1) begin
            d.acc = (prod >>> FRAC) + ACC_W'(q.y);
        end
        if (q.v2) begin
            d.res = clamp16(q.acc, SAT_HI, SAT_LO);
        end
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            q <= '0;
        else
            q <= d;
    end

    assign done = q.v3;
    assign result = q.res;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    lpf_latency_a: assert property (go |-> ##3 done)
        else $error("filter result not ready three clocks after start");
    lpf_history_a: assert property (go |=> q.y == $past(y_prev))
        else $error("filter history not taken at start");

endmodule // lpf_core

//--- rtl/pi_lpf_unit.sv
// AHB-Lite register file around the controller and filter engines
//
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
module pi_lpf_unit import pi_lpf_pkg::*; (
    input wire logic hclk, // System clock
    input wire logic hresetn, // Async reset, active low
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write when high
    input wire logic [2:0] hsize, // Transfer size, word only
    input wire logic hready, // Bus ready
    input wire logic [31:0] hwdata, // Write data
    output logic [31:0] hrdata, // Read data
    output logic hreadyout, // Slave ready
    output logic hresp // Response, always OKAY
);

    // ==========================================================
    // State
    typedef struct packed {
        slot_bank_t regs;
        logic [3:0] trunc;
        logic start_ctrl;
        logic start_filt;
        logic ap_wr;
        logic ap_ctrl;
        logic ap_hit;
        logic [4:0] ap_slot;
        logic [31:0] rdata;
        logic ready;
        logic resp;
    } unit_state_t;

    unit_state_t q, d;
    logic [6:0] dec;
    logic accept;
    logic pi_done, lpf_done;
    logic signed [DATA_W-1:0] pi_res, lpf_res;

    // Map an address to {control, hit, slot}; unaligned or high bits miss
    function automatic logic [6:0] decode_addr(input logic [31:0] a);
        logic [4:0] s;
        logic hit;
        s = 5'h00;
        hit = 1'b1;
        unique case (a[9:2])
            IDX_FILT_COEFF_LO: s = SLOT_FILT_COEFF;
            IDX_FILT_COEFF_HI: s = SLOT_FILT_COEFF + 5'h01;
            IDX_FILT_IN_LO: s = SLOT_FILT_IN;
            IDX_FILT_IN_HI: s = SLOT_FILT_IN + 5'h01;
            IDX_FILT_OUT_LO: s = SLOT_FILT_OUT;
            IDX_FILT_OUT_HI: s = SLOT_FILT_OUT + 5'h01;
            IDX_ERR_LO: s = SLOT_ERR;
            IDX_ERR_HI: s = SLOT_ERR + 5'h01;
            IDX_OUT_LO: s = SLOT_OUT;
            IDX_OUT_HI: s = SLOT_OUT + 5'h01;
            IDX_KP_LO: s = SLOT_KP;
            IDX_KP_HI: s = SLOT_KP + 5'h01;
            IDX_KI_LO: s = SLOT_KI;
            IDX_KI_HI: s = SLOT_KI + 5'h01;
            IDX_MAX_LO: s = SLOT_MAX;
            IDX_MAX_HI: s = SLOT_MAX + 5'h01;
            IDX_MIN_LO: s = SLOT_MIN;
            IDX_MIN_HI: s = SLOT_MIN + 5'h01;
            default: hit = 1'b0;
        endcase
        if (a[31:10] != 22'h000000 || a[1:0] != 2'h0)
            return 7'h00;
        if (a[9:2] == IDX_CONTROL)
            return 7'h40;
        return {1'b0, hit, s};
    endfunction

    // ==========================================================
    // Engines
    pi_core u_pi (
        .hclk(hclk),
        .hresetn(hresetn),
        .go(q.start_ctrl),
        .err(word_at(q.regs, SLOT_ERR)),
        .out_prev(word_at(q.regs, SLOT_OUT)),
        .kp(word_at(q.regs, SLOT_KP)),
        .ki(word_at(q.regs, SLOT_KI)),
        .umax(word_at(q.regs, SLOT_MAX)),
        .umin(word_at(q.regs, SLOT_MIN)),
        .trunc_sel(q.trunc),
        .done(pi_done),
        .result(pi_res)
    );

    lpf_core u_lpf (
        .hclk(hclk),
        .hresetn(hresetn),
        .go(q.start_filt),
        .coeff(word_at(q.regs, SLOT_FILT_COEFF)),
        .sample(word_at(q.regs, SLOT_FILT_IN)),
        .y_prev(word_at(q.regs, SLOT_FILT_OUT)),
        .done(lpf_done),
        .result(lpf_res)
    );

    // ==========================================================
    // Next state: results, bus writes, address phase, read data
    always_comb begin
        d = q;
        dec = decode_addr(haddr);
        accept = hsel && hready && htrans[1];
        // Start bits last one clock; a fresh write sets them again
        d.start_ctrl = 1'b0;
        d.start_filt = 1'b0;
        // Finished runs update their output registers
        if (pi_done) begin
            d.regs[SLOT_OUT] = pi_res[7:0];
            d.regs[SLOT_OUT+5'h01] = pi_res[15:8];
        end
        if (lpf_done) begin
            d.regs[SLOT_FILT_OUT] = lpf_res[7:0];
            d.regs[SLOT_FILT_OUT+5'h01] = lpf_res[15:8];
        end
        // Data phase of a write; software has the last word on a byte
        if (q.ap_wr) begin
            if (q.ap_ctrl) begin
                d.trunc = hwdata[TRUNC_MSB:TRUNC_LSB];
                d.start_ctrl = hwdata[BIT_CTRL_START];
                d.start_filt = hwdata[BIT_FILT_START];
            end else if (q.ap_hit) begin
                d.regs[q.ap_slot] = hwdata[7:0];
            end
        end
        // Address phase capture
        d.ap_wr = accept && hwrite;
        d.ap_ctrl = dec[6];
        d.ap_hit = dec[5];
        d.ap_slot = dec[4:0];
        // Read data is fetched at the address phase from the updated contents
        if (accept && !hwrite) begin
            if (dec[6])
                d.rdata = {24'h000000, d.trunc, 2'h0, d.start_ctrl, d.start_filt};
            else if (dec[5])
                d.rdata = {24'h000000, d.regs[dec[4:0]]};
            else
                d.rdata = 32'h00000000;
        end
        d.ready = 1'b1;
        d.resp = HRESP_OKAY;
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
            q.trunc <= CONTROL_RESET[TRUNC_MSB:TRUNC_LSB];
            q.ready <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // Bus outputs straight from flops
    assign hrdata = q.rdata;
    assign hreadyout = q.ready;
    assign hresp = q.resp;

    // ==========================================================
    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence ctrl_kick_s;
        q.ap_wr && q.ap_ctrl && hwdata[BIT_CTRL_START] ##1 q.start_ctrl;
    endsequence

    sequence filt_kick_s;
        q.ap_wr && q.ap_ctrl && hwdata[BIT_FILT_START] ##1 q.start_filt;
    endsequence

    ctrl_start_clear_a: assert property (q.start_ctrl && !(q.ap_wr && q.ap_ctrl) |=> !q.start_ctrl)
        else $error("controller start bit not cleared after one clock");
    filt_start_clear_a: assert property (q.start_filt && !(q.ap_wr && q.ap_ctrl) |=> !q.start_filt)
        else $error("filter start bit not cleared after one clock");
    ctrl_result_time_a: assert property (ctrl_kick_s |-> ##3 pi_done ##1
                                         ($past(q.ap_wr && q.ap_hit && q.ap_slot[4:1] == SLOT_OUT[4:1]) ||
                                          word_at(q.regs, SLOT_OUT) == $past(pi_res)))
        else $error("controller output register not updated four clocks after start");
    filt_result_time_a: assert property (filt_kick_s |-> ##3 lpf_done ##1
                                         ($past(q.ap_wr && q.ap_hit && q.ap_slot[4:1] == SLOT_FILT_OUT[4:1]) ||
                                          word_at(q.regs, SLOT_FILT_OUT) == $past(lpf_res)))
        else $error("filter output register not updated four clocks after start");
    bus_okay_a: assert property (hreadyout && hresp == HRESP_OKAY)
        else $error("slave stalled or answered with an error");

endmodule // pi_lpf_unit

//--- dv/test_pi_lpf_unit.sv
// Self-checking bench for the controller and filter register unit
`timescale 1ns/1ps
module test_pi_lpf_unit import pi_lpf_pkg::*; ();

    // ==========================================================
    // Signals and state
    logic hclk;
    logic hresetn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hready;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    int bad_count;
    int checks;
    int cycles;
    logic [15:0] got;
    logic [7:0] b;
    logic signed [15:0] kp_v, ki_v, mx_v, mn_v, eprev_v, u_v;
    logic [3:0] code_v;
    logic [7:0] pair_lo [9] = '{IDX_FILT_COEFF_LO, IDX_FILT_IN_LO, IDX_FILT_OUT_LO, IDX_ERR_LO, IDX_OUT_LO,
                                IDX_KP_LO, IDX_KI_LO, IDX_MAX_LO, IDX_MIN_LO};
    logic [15:0] filt_tab [4][3] = '{'{16'h4000, 16'h07D0, 16'h03E8}, '{16'h7FFF, 16'h7FFF, 16'h8000},
                                     '{16'h8000, 16'hFF9C, 16'h012C}, '{16'h2000, 16'h8000, 16'h7FFF}};

    // ==========================================================
    // Design under test, single slave so hready follows hreadyout
    assign hready = hreadyout;
    pi_lpf_unit dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp));

    // Clock at 250 MHz
    always #2 hclk = ~hclk;

    // Hang guard, far above the few hundred cycles the tests need
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    // ==========================================================
    // Reporting
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        if (bad_count == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ==========================================================
    // Bus transfers, entered just after a rising edge
    task automatic bus_xfer(input logic [7:0] idx, input logic wr, input logic [7:0] d, output logic [7:0] q);
        haddr <= {22'h000000, idx, 2'b00};
        hwrite <= wr;
        htrans <= HTRANS_NONSEQ;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h000000, d};
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata[7:0];
        check({15'h0000, hresp}, {15'h0000, HRESP_OKAY});
    endtask

    task automatic bus_write(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] q;
        bus_xfer(idx, 1'b1, d, q);
    endtask

    task automatic bus_read(input logic [7:0] idx, output logic [7:0] q);
        bus_xfer(idx, 1'b0, 8'h00, q);
    endtask

    // Low byte sits at the lower index
    task automatic wr16(input logic [7:0] lo, input logic [15:0] v);
        bus_write(lo, v[7:0]);
        bus_write(lo + 8'h01, v[15:8]);
    endtask

    task automatic rd16(input logic [7:0] lo, output logic [15:0] v);
        bus_read(lo, v[7:0]);
        bus_read(lo + 8'h01, v[15:8]);
    endtask

    // ==========================================================
    // Reference arithmetic
    function automatic logic [15:0] pi_model(input logic signed [15:0] e);
        longint acc;
        longint u;
        acc = longint'(kp_v) * (longint'(e) - longint'(eprev_v)) + longint'(ki_v) * longint'(e);
        acc = acc >>> (8 + code_v);
        u = longint'(u_v) + acc;
        if (u > longint'(mx_v))
            u = longint'(mx_v);
        else if (u < longint'(mn_v))
            u = longint'(mn_v);
        return u[15:0];
    endfunction

    function automatic logic [15:0] lpf_model(input logic signed [15:0] k, x, y);
        longint v;
        v = longint'(y) + ((longint'(k) * (longint'(x) - longint'(y))) >>> 15);
        if (v > 32767)
            v = 32767;
        else if (v < -32768)
            v = -32768;
        return v[15:0];
    endfunction

    // ==========================================================
    // Engine runs
    task automatic set_pi(input logic [15:0] kp, ki, mx, mn, input logic [3:0] code);
        kp_v = kp;
        ki_v = ki;
        mx_v = mx;
        mn_v = mn;
        code_v = code;
        wr16(IDX_KP_LO, kp);
        wr16(IDX_KI_LO, ki);
        wr16(IDX_MAX_LO, mx);
        wr16(IDX_MIN_LO, mn);
        bus_write(IDX_CONTROL, {code, 4'h0});
    endtask

    // Result must stand by the read taken four edges after the start write
    task automatic pi_step(input logic signed [15:0] e, input logic disturb);
        logic [15:0] exp;
        exp = pi_model(e);
        wr16(IDX_ERR_LO, e);
        bus_write(IDX_CONTROL, {code_v, 4'h2});
        if (disturb)
            wr16(IDX_ERR_LO, ~e);
        else
            repeat (3) @(posedge hclk);
        rd16(IDX_OUT_LO, got);
        check(got, exp);
        eprev_v = e;
        u_v = exp;
    endtask

    task automatic lpf_step(input logic [15:0] k, x, y);
        wr16(IDX_FILT_COEFF_LO, k);
        wr16(IDX_FILT_IN_LO, x);
        wr16(IDX_FILT_OUT_LO, y);
        bus_write(IDX_CONTROL, {code_v, 4'h1});
        repeat (3) @(posedge hclk);
        rd16(IDX_FILT_OUT_LO, got);
        check(got, lpf_model(k, x, y));
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b1;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        bad_count = 0;
        checks = 0;
        cycles = 0;
        eprev_v = 16'h0000;
        u_v = 16'h0000;
        code_v = 4'h4;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // Reset values, then read-back of distinct negative signed words
        for (int i = 0; i < 9; i++) begin
            rd16(pair_lo[i], got);
            check(got, 16'h0000);
        end
        bus_read(IDX_CONTROL, b);
        check({8'h00, b}, 16'h0040);
        for (int i = 0; i < 9; i++) begin
            wr16(pair_lo[i], 16'h8001 + 16'h0F0F * i[15:0]);
            rd16(pair_lo[i], got);
            check(got, 16'h8001 + 16'h0F0F * i[15:0]);
            wr16(pair_lo[i], 16'h0000);
        end
        // Unmapped index ignored, reserved control bits read zero
        bus_write(8'hE0, 8'h5A);
        bus_read(8'hE0, b);
        check({8'h00, b}, 16'h0000);
        bus_write(IDX_CONTROL, 8'hFC);
        bus_read(IDX_CONTROL, b);
        check({8'h00, b}, 16'h00F0);
        // Start bits clear themselves after one clock
        bus_write(IDX_CONTROL, 8'h43);
        @(posedge hclk);
        bus_read(IDX_CONTROL, b);
        check({8'h00, b}, 16'h0040);
        u_v = 16'h0000;
        // Gains of one and one half at twelve fraction bits
        set_pi(16'h1000, 16'h0800, 16'h7FFF, 16'h8000, 4'h4);
        eprev_v = 16'h0000;
        pi_step(16'sd100, 1'b0);
        pi_step(-16'sd50, 1'b1);
        // Limits on both sides
        set_pi(16'h1000, 16'h1000, 16'd200, -16'sd300, 4'h4);
        pi_step(16'sd1000, 1'b0);
        pi_step(-16'sd2000, 1'b0);
        // History restored by software between shared loops
        wr16(IDX_OUT_LO, 16'h0123);
        u_v = 16'h0123;
        pi_step(16'sd7, 1'b0);
        // Every truncation code, sign alternating
        set_pi(16'h0100, 16'h0200, 16'h7FFF, 16'h8000, 4'h0);
        for (int c = 0; c < 16; c++) begin
            wr16(IDX_OUT_LO, 16'h0000);
            u_v = 16'h0000;
            code_v = c[3:0];
            pi_step(c[0] ? -16'sd1000 : 16'sd1000, 1'b0);
        end
        // Filter cases including full-scale input and history
        for (int i = 0; i < 4; i++)
            lpf_step(filt_tab[i][0], filt_tab[i][1], filt_tab[i][2]);
        tally_and_finish();
    end

endmodule // test_pi_lpf_unit
